// File: logic/dacc_params.svh
// offsets, field positions, reset values and timing counts of the converter control
`ifndef DACC_PARAMS_SVH
`define DACC_PARAMS_SVH

`define DACC_CLK_MHZ 125
`define DACC_SLOW_PERIOD_NS 500
`define DACC_PLL_PERIOD_NS 50
`define DACC_SLOW_CYC ((`DACC_SLOW_PERIOD_NS * `DACC_CLK_MHZ) / 1000)
`define DACC_PLL_CYC ((`DACC_PLL_PERIOD_NS * `DACC_CLK_MHZ) / 1000)
`define DACC_LATENCY 6

`define DACC_OFS_CTRL 8'h00
`define DACC_OFS_STATUS 8'h04
`define DACC_OFS_PERIOD 8'h08

`define DACC_CTRL_PLL_DIS 0
`define DACC_CTRL_TWOS 1
`define DACC_CTRL_RESET 2'h0

`define DACC_ST_LOW_POWER 0
`define DACC_ST_PLL_ON 1
`define DACC_ST_INT_REF 2
`define DACC_ST_RATE_FAULT 3

`define DACC_RESP_OKAY 2'h0
`define DACC_RESP_SLVERR 2'h2

`endif

// File: logic/dacc_pkg.sv
// types of the dual converter output and clock control block
`default_nettype none

package dacc_pkg;

    typedef struct packed {
        logic over_range;
        logic [11:0] word;
    } dacc_sample_t;

    typedef struct packed {
        logic sclk_prev;
        dacc_sample_t [5:0] pipe_a;
        dacc_sample_t [5:0] pipe_b;
        dacc_sample_t out_a;
        dacc_sample_t out_b;
        logic dv_a;
        logic dv_b;
        logic [6:0] gap;
        logic [6:0] period;
        logic low_power;
        logic rate_fault;
        logic pll_disable;
        logic twos;
        logic pll_enable;
        logic int_ref;
        logic aw_got;
        logic [7:0] awaddr_q;
        logic w_got;
        logic [31:0] wdata_q;
        logic wstrb0_q;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } dacc_state_t;

endpackage

`default_nettype wire

// File: logic/dacc_top.sv
// dual converter output pipeline, rate supervision and control registers
//
// The placing of the registers and register access over AXI4-Lite were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
`include "dacc_params.svh"

module dacc_top (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic sample_clk,
    input wire dacc_pkg::dacc_sample_t conv_a,
    input wire dacc_pkg::dacc_sample_t conv_b,
    input wire logic reference_source_select,
    input wire logic serial_enable_n,
    output logic [11:0] data_chan_a,
    output logic [11:0] data_chan_b,
    output logic word_valid_chan_a,
    output logic word_valid_chan_b,
    output logic over_range_flag_chan_a,
    output logic over_range_flag_chan_b,
    output logic low_power,
    output logic pll_enable,
    output logic rate_fault,
    output logic ref_buffer_enable,
    input wire logic awvalid,
    output logic awready,
    input wire logic [7:0] awaddr,
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    input wire logic arvalid,
    output logic arready,
    input wire logic [7:0] araddr,
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp
);
    import dacc_pkg::*;

    localparam logic [6:0] SLOW_CYC = 7'(`DACC_SLOW_CYC);
    localparam logic [6:0] PLL_CYC = 7'(`DACC_PLL_CYC);

    dacc_state_t st;
    dacc_state_t next_st;
    logic edge_seen;

    // output coding: two's complement is offset binary with MSB flipped
    function automatic logic [11:0] fmt_word(input dacc_sample_t s,
                                             input logic twos);
        fmt_word = {s.word[11] ^ twos, s.word[10:0]};
    endfunction

    function automatic logic [31:0] reg_read(input dacc_state_t s,
                                             input logic [7:0] a);
        reg_read = 32'h0;
        unique case (a)
            `DACC_OFS_CTRL: begin
                reg_read[`DACC_CTRL_PLL_DIS] = s.pll_disable;
                reg_read[`DACC_CTRL_TWOS] = s.twos;
            end
            `DACC_OFS_STATUS: begin
                reg_read[`DACC_ST_LOW_POWER] = s.low_power;
                reg_read[`DACC_ST_PLL_ON] = s.pll_enable;
                reg_read[`DACC_ST_INT_REF] = s.int_ref;
                reg_read[`DACC_ST_RATE_FAULT] = s.rate_fault;
            end
            `DACC_OFS_PERIOD: reg_read[6:0] = s.period;
            default: reg_read = 32'h0;
        endcase
    endfunction

    function automatic logic reg_mapped(input logic [7:0] a);
        reg_mapped = (a == `DACC_OFS_CTRL) || (a == `DACC_OFS_STATUS) ||
                     (a == `DACC_OFS_PERIOD);
    endfunction

    assign edge_seen = sample_clk && !st.sclk_prev;

    always_comb begin
        next_st = st;
        next_st.sclk_prev = sample_clk;

        // conversion pipeline, shared edge for both channels
        if (edge_seen) begin
            next_st.pipe_a = {st.pipe_a[4:0], conv_a};
            next_st.pipe_b = {st.pipe_b[4:0], conv_b};
            next_st.out_a.word = fmt_word(st.pipe_a[5], st.twos);
            next_st.out_b.word = fmt_word(st.pipe_b[5], st.twos);
            next_st.out_a.over_range = st.pipe_a[5].over_range;
            next_st.out_b.over_range = st.pipe_b[5].over_range;
            next_st.dv_a = 1'b0;
            next_st.dv_b = 1'b0;
        end else begin
            // rise one cycle after the word settles, capture on it
            next_st.dv_a = 1'b1;
            next_st.dv_b = 1'b1;
        end

        // sample rate supervision
        if (edge_seen) begin
            // a stopped clock saturates at the gap ceiling
            next_st.period = (st.gap == 7'h7F) ? st.gap : st.gap + 7'h01;
            next_st.gap = 7'h00;
            if (st.gap < SLOW_CYC) begin
                next_st.low_power = 1'b0;
            end
            next_st.rate_fault = st.pll_enable && (st.gap >= PLL_CYC);
        end else begin
            if (st.gap != 7'h7F) begin
                next_st.gap = st.gap + 7'h01;
            end
            if (st.gap >= SLOW_CYC) begin
                next_st.low_power = 1'b1;
            end
            // a disabled loop has no minimum rate to break
            if (!st.pll_enable) begin
                next_st.rate_fault = 1'b0;
            end
        end

        next_st.int_ref = reference_source_select;

        // write channel: address and data in either order
        if (awvalid && st.awready) begin
            next_st.aw_got = 1'b1;
            next_st.awaddr_q = awaddr;
        end
        if (wvalid && st.wready) begin
            next_st.w_got = 1'b1;
            next_st.wdata_q = wdata;
            next_st.wstrb0_q = wstrb[0];
        end
        if (st.bvalid && bready) begin
            next_st.bvalid = 1'b0;
        end
        if (st.aw_got && st.w_got && !st.bvalid) begin
            next_st.aw_got = 1'b0;
            next_st.w_got = 1'b0;
            next_st.bvalid = 1'b1;
            next_st.bresp = reg_mapped(st.awaddr_q) ? `DACC_RESP_OKAY :
                                                      `DACC_RESP_SLVERR;
            if (st.awaddr_q == `DACC_OFS_CTRL && st.wstrb0_q) begin
                next_st.pll_disable = st.wdata_q[`DACC_CTRL_PLL_DIS];
                next_st.twos = st.wdata_q[`DACC_CTRL_TWOS];
            end
        end
        // serial enable pulse wins over a bus write
        if (!serial_enable_n) begin
            {next_st.twos, next_st.pll_disable} = `DACC_CTRL_RESET;
        end
        next_st.pll_enable = !next_st.pll_disable;
        next_st.awready = !next_st.aw_got && !next_st.bvalid;
        next_st.wready = !next_st.w_got && !next_st.bvalid;

        // read channel
        if (st.rvalid && rready) begin
            next_st.rvalid = 1'b0;
        end
        if (arvalid && st.arready) begin
            next_st.rvalid = 1'b1;
            next_st.rdata = reg_read(st, araddr);
            next_st.rresp = reg_mapped(araddr) ? `DACC_RESP_OKAY :
                                                 `DACC_RESP_SLVERR;
        end
        next_st.arready = !next_st.rvalid;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st <= '0;
            st.pll_enable <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    assign data_chan_a = st.out_a.word;
    assign data_chan_b = st.out_b.word;
    assign word_valid_chan_a = st.dv_a;
    assign word_valid_chan_b = st.dv_b;
    assign over_range_flag_chan_a = st.out_a.over_range;
    assign over_range_flag_chan_b = st.out_b.over_range;
    assign low_power = st.low_power;
    assign pll_enable = st.pll_enable;
    assign rate_fault = st.rate_fault;
    assign ref_buffer_enable = st.int_ref;
    assign awready = st.awready;
    assign wready = st.wready;
    assign bvalid = st.bvalid;
    assign bresp = st.bresp;
    assign arready = st.arready;
    assign rvalid = st.rvalid;
    assign rdata = st.rdata;
    assign rresp = st.rresp;

    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    AST_CAPTURE_BOTH: assert property (
        edge_seen |=> st.pipe_a[0] == $past(conv_a) &&
                      st.pipe_b[0] == $past(conv_b))
        else $error("samples not captured on sample edge");

    AST_LATENCY_WORD: assert property (
        edge_seen |=> data_chan_a == fmt_word($past(st.pipe_a[5]),
                                              $past(st.twos)))
        else $error("channel a word not taken from last stage");

    AST_MSB_FLIP: assert property (
        edge_seen && st.twos |=>
            data_chan_b[11] != $past(st.pipe_b[5].word[11]) &&
            data_chan_b[10:0] == $past(st.pipe_b[5].word[10:0]))
        else $error("two's complement coding wrong");

    AST_SIMUL_UPDATE: assert property (
        $changed(data_chan_a) || $changed(data_chan_b) |-> $past(edge_seen))
        else $error("word changed without a sample edge");

    AST_VALID_STROBE: assert property (
        edge_seen ##1 !edge_seen |-> !word_valid_chan_a ##1
                                     (word_valid_chan_a && word_valid_chan_b))
        else $error("word valid strobe misaligned");

    AST_OVR_FOLLOWS: assert property (
        edge_seen |=> over_range_flag_chan_a ==
                      $past(st.pipe_a[5].over_range))
        else $error("over-range flag out of step with its word");

    AST_LOW_POWER_ENTER: assert property (
        !edge_seen && st.gap >= SLOW_CYC |=> low_power)
        else $error("low power not entered on slow clock");

    AST_LOW_POWER_EXIT: assert property (
        low_power && edge_seen && st.gap < SLOW_CYC |=> !low_power)
        else $error("low power not left on fast clock");

    AST_RATE_FAULT: assert property (
        edge_seen && pll_enable && st.gap >= PLL_CYC |=> rate_fault)
        else $error("slow clock with loop enabled not flagged");

    AST_SERIAL_CLEAR: assert property (
        !serial_enable_n |=> pll_enable && st.twos == 1'b0)
        else $error("serial enable pulse did not clear settings");

    AST_REF_SELECT: assert property (
        !reference_source_select |=> !ref_buffer_enable)
        else $error("internal reference buffer not tri-stated");

    AST_LATENCY_WORD_B: assert property (
        edge_seen |=> data_chan_b == fmt_word($past(st.pipe_b[5]),
                                              $past(st.twos)))
        else $error("channel b word not taken from last stage");

    AST_OVR_FOLLOWS_B: assert property (
        edge_seen |=> over_range_flag_chan_b ==
                      $past(st.pipe_b[5].over_range))
        else $error("channel b over-range flag out of step");

    AST_PIPE_SHIFT: assert property (
        edge_seen |=> st.pipe_a[5] == $past(st.pipe_a[4]) &&
                      st.pipe_b[5] == $past(st.pipe_b[4]))
        else $error("pipeline did not advance on sample edge");

    AST_PIPE_HOLD: assert property (
        !edge_seen |=> $stable(st.pipe_a) && $stable(st.pipe_b))
        else $error("pipeline moved without a sample edge");

    AST_DATA_HOLD: assert property (
        !edge_seen |=> $stable(data_chan_a) && $stable(data_chan_b))
        else $error("output word changed between sample edges");

    AST_VALID_PAIR: assert property (
        word_valid_chan_a == word_valid_chan_b)
        else $error("channel word valid strobes differ");

    AST_GAP_RESTART: assert property (
        edge_seen |=> st.gap == 7'h00)
        else $error("rate counter not restarted on sample edge");

    AST_LOW_POWER_HOLD: assert property (
        low_power && !edge_seen |=> low_power)
        else $error("low power left without a sample edge");

    AST_RATE_OK: assert property (
        edge_seen && st.gap < PLL_CYC |=> !rate_fault)
        else $error("fast clock flagged as too slow");

    AST_RATE_FAULT_CLEAR: assert property (
        !pll_enable |=> !rate_fault)
        else $error("rate fault kept with loop disabled");

    AST_PLL_FOLLOWS_CTRL: assert property (
        pll_enable != st.pll_disable)
        else $error("loop enable disagrees with control setting");

    AST_REF_FOLLOW: assert property (
        reference_source_select |=> ref_buffer_enable)
        else $error("internal reference buffer not enabled");

    AST_READ_UNMAPPED: assert property (
        arvalid && arready && araddr > `DACC_OFS_PERIOD |=>
            rvalid && rresp == `DACC_RESP_SLVERR)
        else $error("unmapped read not refused");

    AST_READ_BLOCK: assert property (
        rvalid |-> !arready)
        else $error("read address taken while answer pending");

    AST_WRITE_BLOCK: assert property (
        bvalid |-> !awready && !wready)
        else $error("write taken while response pending");

    COV_SAMPLE_FLOW: cover property (edge_seen ##[2:20] edge_seen);
    COV_LOW_POWER: cover property ($rose(low_power) ##[1:200] !low_power);
    COV_CTRL_WRITE: cover property (bvalid && bready && bresp == 2'h0);
    COV_TWOS_OUT: cover property (st.twos && $changed(data_chan_a));
    COV_RATE_FAULT: cover property ($rose(rate_fault));

endmodule // dacc_top

`default_nettype wire

// File: test/dacc_capture.sv
// downstream capture logic latching each channel word on its valid strobe
`timescale 1ns/100ps
`default_nettype none

module dacc_capture (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic word_valid_chan_a,
    input wire logic word_valid_chan_b,
    input wire logic [11:0] data_chan_a,
    input wire logic [11:0] data_chan_b,
    input wire logic over_range_flag_chan_a,
    input wire logic over_range_flag_chan_b,
    output var dacc_pkg::dacc_sample_t cap_a,
    output var dacc_pkg::dacc_sample_t cap_b
);
    import dacc_pkg::*;
    logic prev_a;
    logic prev_b;
    // latch on the rising strobe, when the word has stood a full cycle
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            prev_a <= 1'b1;
            prev_b <= 1'b1;
        end else begin
            prev_a <= word_valid_chan_a;
            prev_b <= word_valid_chan_b;
            if (word_valid_chan_a && !prev_a) begin
                cap_a <= {over_range_flag_chan_a, data_chan_a};
            end
            if (word_valid_chan_b && !prev_b) begin
                cap_b <= {over_range_flag_chan_b, data_chan_b};
            end
        end
    end
endmodule // dacc_capture

`default_nettype wire

// File: test/dacc_top_test.sv
// self-checking bench of the converter output and control block
`timescale 1ns/100ps
`default_nettype none
`include "dacc_params.svh"

module dacc_top_test;
    import dacc_pkg::*;
    // a sample shows up six sample periods after its capturing edge
    localparam int LAT = `DACC_LATENCY;
    logic aclk = 0, aresetn = 0, sample_clk = 0, serial_enable_n = 1;
    logic reference_source_select = 1;
    dacc_sample_t conv_a = '0, conv_b = '0, cap_a, cap_b, e;
    logic [11:0] data_chan_a, data_chan_b;
    logic word_valid_chan_a, word_valid_chan_b, low_power, pll_enable;
    logic over_range_flag_chan_a, over_range_flag_chan_b;
    logic rate_fault, ref_buffer_enable;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic [7:0] awaddr = '0, araddr = '0;
    logic [31:0] wdata = '0, rdata, rd;
    logic [3:0] wstrb = '0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp, rs;
    int fails = 0, n_checks = 0, cyc = 0;
    logic [12:0] ra [8] = '{13'h1FFF, 13'h0000, 13'h0800, 13'h07FF,
        13'h0001, 13'h1ABC, 13'h0FFE, 13'h1123};

    always #4 aclk = ~aclk;

    dacc_top u_dacc_top (.aclk, .aresetn, .sample_clk, .conv_a, .conv_b,
        .reference_source_select, .serial_enable_n, .data_chan_a,
        .data_chan_b, .word_valid_chan_a, .word_valid_chan_b,
        .over_range_flag_chan_a, .over_range_flag_chan_b, .low_power,
        .pll_enable, .rate_fault, .ref_buffer_enable, .awvalid, .awready,
        .awaddr, .wvalid, .wready, .wdata, .wstrb, .bvalid, .bready, .bresp,
        .arvalid, .arready, .araddr, .rvalid, .rready, .rdata, .rresp);

    dacc_capture u_dacc_capture (.aclk, .aresetn, .word_valid_chan_a,
        .word_valid_chan_b, .data_chan_a, .data_chan_b,
        .over_range_flag_chan_a, .over_range_flag_chan_b, .cap_a, .cap_b);

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic chk(input logic [33:0] g, input logic [33:0] x,
        input string m);
        n_checks++;
        if (g !== x) begin
            fails++;
            $display("[ERR] %0t %s", $time, m);
        end
    endtask

    // ready is looked at on the falling edge, the transfer is the next rise
    task automatic axw(input logic [7:0] a, input logic [31:0] d);
        bit da = 0, dw = 0, ta, tw;
        @(posedge aclk);
        awvalid <= 1;
        awaddr <= a;
        wvalid <= 1;
        wdata <= d;
        wstrb <= 4'hF;
        bready <= 1;
        while (!(da && dw)) begin
            @(negedge aclk);
            ta = !da && awready;
            tw = !dw && wready;
            @(posedge aclk);
            if (ta) awvalid <= 0;
            if (tw) wvalid <= 0;
            da |= ta;
            dw |= tw;
        end
        do @(negedge aclk); while (!bvalid);
        rs = bresp;
        @(posedge aclk);
        bready <= 0;
    endtask

    task automatic axr(input logic [7:0] a);
        @(posedge aclk);
        arvalid <= 1;
        araddr <= a;
        rready <= 1;
        do @(negedge aclk); while (!arready);
        @(posedge aclk);
        arvalid <= 0;
        do @(negedge aclk); while (!rvalid);
        rd = rdata;
        rs = rresp;
        @(posedge aclk);
        rready <= 0;
    endtask

    // one sample clock period of gap cycles, high for half of it
    task automatic smp(input dacc_sample_t a, input int gap);
        @(posedge aclk);
        sample_clk <= 1;
        conv_a <= a;
        conv_b <= ~a;
        @(posedge aclk);
        @(negedge aclk);
        chk({word_valid_chan_a, word_valid_chan_b}, 0, "valid low");
        repeat (gap / 2 - 1) @(posedge aclk);
        sample_clk <= 0;
        repeat (gap - gap / 2 - 1) @(posedge aclk);
        @(negedge aclk);
        chk({word_valid_chan_a, word_valid_chan_b}, 3, "valid high");
    endtask

    always @(posedge aclk) begin
        cyc++;
        if (cyc == 20000) begin
            fails++;
            $display("[ERR] %0t run too long", $time);
            give_verdict();
        end
    end

    initial begin
        repeat (4) @(posedge aclk);
        aresetn <= 1;
        @(negedge aclk);
        chk(pll_enable, 1, "loop after reset");
        axr(`DACC_OFS_CTRL);
        chk(rd, 0, "control after reset");
        $display("reset test done");
        for (int f = 0; f < 2; f++) begin
            axw(`DACC_OFS_CTRL, f << 1);
            for (int i = 0; i < 8 + LAT; i++) begin
                smp(ra[i % 8], 4);
                if (i >= LAT) begin
                    e = ra[i - LAT] ^ (f ? 13'h0800 : 13'h0000);
                    chk(cap_a, e, "chan a word");
                    chk(cap_b, e ^ 13'h1FFF, "chan b word");
                end
            end
        end
        $display("stream test done");
        axw(`DACC_OFS_CTRL, 0);
        smp(ra[0], 10);
        smp(ra[1], 10);
        chk(rate_fault, 1, "slow clock with loop on");
        axr(`DACC_OFS_PERIOD);
        chk(rd, 32'h0000000A, "measured period");
        axw(`DACC_OFS_CTRL, 1);
        @(negedge aclk);
        chk({pll_enable, rate_fault}, 0, "loop off");
        repeat (70) @(negedge aclk);
        chk(low_power, 1, "stopped clock");
        axr(`DACC_OFS_STATUS);
        chk(rd, 32'h5, "status in low power");
        smp(ra[2], 4);
        smp(ra[3], 4);
        chk(low_power, 0, "resume");
        $display("rate test done");
        @(posedge aclk);
        reference_source_select <= 0;
        repeat (2) @(negedge aclk);
        chk(ref_buffer_enable, 0, "reference buffer off");
        axr(`DACC_OFS_STATUS);
        chk(rd, 0, "status external reference");
        @(posedge aclk);
        reference_source_select <= 1;
        axr(8'h0C);
        chk({rs, rd}, {`DACC_RESP_SLVERR, 32'h0}, "unmapped read");
        axw(8'h10, 32'hFFFFFFFF);
        chk(rs, `DACC_RESP_SLVERR, "unmapped write");
        axw(`DACC_OFS_CTRL, 3);
        @(posedge aclk);
        serial_enable_n <= 0;
        @(posedge aclk);
        serial_enable_n <= 1;
        axr(`DACC_OFS_CTRL);
        chk({rd, pll_enable}, {32'h0, 1'b1}, "serial enable clear");
        @(posedge aclk);
        aresetn <= 0;
        repeat (2) @(negedge aclk);
        chk({pll_enable, low_power, word_valid_chan_a}, 3'b100, "reset");
        $display("register test done");
        give_verdict();
    end
endmodule // dacc_top_test

`default_nettype wire
